/* File: include/wam_regs.svh */
`ifndef WAM_REGS_SVH
`define WAM_REGS_SVH

// Register indexes; byte address is four times the index
`define WAM_IDX_WAKE_CTRL   8'h32
`define WAM_IDX_AMP_CFG     8'h33
`define WAM_IDX_AMP_REF     8'h34
`define WAM_IDX_AMP_AVG     8'h35
`define WAM_IDX_AMP_RESULT  8'h36
`define WAM_IDX_IRQ_STATUS  8'h40
`define WAM_IDX_IRQ_MASK    8'h41

// Reset values
`define WAM_RST_WAKE_CTRL   8'h00
`define WAM_RST_AMP_CFG     8'h00
`define WAM_RST_AMP_REF     8'h00
`define WAM_RST_AMP_AVG     8'h00
`define WAM_RST_AMP_RESULT  8'h00
`define WAM_RST_IRQ_STATUS  4'h0
`define WAM_RST_IRQ_MASK    4'h0

// Interrupt status bit positions
`define WAM_IRQ_TIMER_BIT   0
`define WAM_IRQ_AMP_BIT     1
`define WAM_IRQ_PHASE_BIT   2
`define WAM_IRQ_CAP_BIT     3

// Timing: clock rate and the two base periods
`define WAM_CLK_KHZ         100000
`define WAM_FAST_BASE_MS    10
`define WAM_SLOW_BASE_MS    100
`define WAM_FAST_CYCLES     (`WAM_FAST_BASE_MS * `WAM_CLK_KHZ)
`define WAM_SLOW_RATIO      (`WAM_SLOW_BASE_MS / `WAM_FAST_BASE_MS)

`endif

/* File: include/wam_pkg.sv */
`default_nettype none
package wam_pkg;

    // Wake-up timer control fields, msb first
    typedef struct packed {
        logic       range_fast;
        logic [2:0] timeout_code;
        logic       irq_every_timeout;
        logic       amp_on_timeout;
        logic       phase_on_timeout;
        logic       cap_on_timeout;
    } wam_ctrl_t;

    // Amplitude measurement configuration fields, msb first
    typedef struct packed {
        logic [3:0] amplitude_delta_threshold;
        logic       include_trigger_in_average;
        logic [1:0] average_weight_code;
        logic       reference_source_select;
    } wam_amp_cfg_t;

    // Result handed back by the amplitude converter
    typedef struct packed {
        logic       done;
        logic [7:0] value;
    } wam_meas_t;

    // Amplitude sequencer, one-hot
    typedef enum logic [2:0] {
        WAM_AMP_IDLE = 3'b001,
        WAM_AMP_WAIT = 3'b010,
        WAM_AMP_EVAL = 3'b100
    } wam_amp_state_t;

endpackage : wam_pkg
`default_nettype wire

/* File: src/wam_top.sv */
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "wam_regs.svh"

module wam_top #(
    parameter int unsigned BASE_CYCLES = `WAM_FAST_CYCLES
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    // Wishbone classic slave
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [9:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    // Amplitude converter
    output logic                     amp_meas_start,
    input  wire wam_pkg::wam_meas_t  amp_meas,
    // Phase and capacitance units
    output logic                     phase_meas_start,
    input  wire logic                phase_change_evt,
    output logic                     cap_meas_start,
    input  wire logic                cap_change_evt,
    // Interrupt
    output logic                     irq
);
    import wam_pkg::*;

    localparam int PRE_W = (BASE_CYCLES > 1) ? $clog2(BASE_CYCLES) : 1;
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(BASE_CYCLES - 1);
    localparam logic [3:0] DEC_LAST = 4'(`WAM_SLOW_RATIO - 1);

    //************************************************************
    // Helper functions
    //************************************************************

    // Weight code to right-shift amount: 2, 3, 4, 5 (divide by 4, 8, 16, 32)
    function automatic logic [2:0] wam_weight_shift(
        input logic [1:0] code
    );
        wam_weight_shift = 3'(code) + 3'h2;
    endfunction : wam_weight_shift

    // Absolute difference of two bytes
    function automatic logic [7:0] wam_abs_diff(
        input logic [7:0] a,
        input logic [7:0] b
    );
        wam_abs_diff = (a >= b) ? (a - b) : (b - a);
    endfunction : wam_abs_diff

    // Write strobe for one register index
    function automatic logic wam_wr_hit(
        input logic       wr,
        input logic [7:0] idx,
        input logic [7:0] target
    );
        wam_wr_hit = wr && (idx == target);
    endfunction : wam_wr_hit

    //************************************************************
    // Registers and bus decode
    //************************************************************

    wam_ctrl_t        ctrl;
    wam_amp_cfg_t     amp_cfg;
    logic [7:0]       fixed_reference_value;
    logic [7:0]       amp_average;
    logic [7:0]       latest_result_value;
    logic [3:0]       irq_status;
    logic [3:0]       irq_mask;
    logic [3:0]       next_irq_status;
    logic [3:0]       irq_set;
    logic [7:0]       bus_idx;
    logic             bus_req;
    logic             bus_wr;
    logic             ctrl_wr;
    logic [7:0]       rd_byte;

    assign bus_idx = wb_adr_i[9:2];
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // Only lane 0 carries data; writes without it change nothing
    assign bus_wr  = bus_req && wb_we_i && wb_sel_i[0];
    assign ctrl_wr = wam_wr_hit(bus_wr, bus_idx, `WAM_IDX_WAKE_CTRL);

    // Ack one cycle after the strobe, dropped the cycle after
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // Read mux; unmapped indexes read as zero
    always_comb begin
        rd_byte = 8'h00;
        unique case (bus_idx)
            `WAM_IDX_WAKE_CTRL:  rd_byte = ctrl;
            `WAM_IDX_AMP_CFG:    rd_byte = amp_cfg;
            `WAM_IDX_AMP_REF:    rd_byte = fixed_reference_value;
            `WAM_IDX_AMP_AVG:    rd_byte = amp_average;
            `WAM_IDX_AMP_RESULT: rd_byte = latest_result_value;
            `WAM_IDX_IRQ_STATUS: rd_byte = {4'h0, irq_status};
            `WAM_IDX_IRQ_MASK:   rd_byte = {4'h0, irq_mask};
            default:             rd_byte = 8'h00;
        endcase
    end

    // Read data registered with the ack
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req) begin
            wb_dat_o <= {24'h00_0000, rd_byte};
        end
    end

    // Wake-up timer control; the same write restarts the timer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= `WAM_RST_WAKE_CTRL;
        end else if (ctrl_wr) begin
            ctrl <= wb_dat_i[7:0];
        end
    end

    // Amplitude configuration; takes effect at the next evaluation
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            amp_cfg <= `WAM_RST_AMP_CFG;
        end else if (wam_wr_hit(bus_wr, bus_idx, `WAM_IDX_AMP_CFG)) begin
            amp_cfg <= wb_dat_i[7:0];
        end
    end

    // Fixed comparison value written by software
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fixed_reference_value <= `WAM_RST_AMP_REF;
        end else if (wam_wr_hit(bus_wr, bus_idx, `WAM_IDX_AMP_REF)) begin
            fixed_reference_value <= wb_dat_i[7:0];
        end
    end

    // Interrupt mask, same layout as the status bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask <= `WAM_RST_IRQ_MASK;
        end else if (wam_wr_hit(bus_wr, bus_idx, `WAM_IDX_IRQ_MASK)) begin
            irq_mask <= wb_dat_i[3:0];
        end
    end

    //************************************************************
    // Wake-up timer
    //************************************************************

    logic [PRE_W-1:0] prescale;
    logic [3:0]       decade;
    logic [2:0]       period_cnt;
    logic             timer_run;
    logic             fast_tick;
    logic             base_tick;
    logic             timeout;

    // Timer idles while no timeout action is enabled, saving power
    assign timer_run = ctrl.irq_every_timeout || ctrl.amp_on_timeout
                    || ctrl.phase_on_timeout || ctrl.cap_on_timeout;
    assign fast_tick = timer_run && (prescale == PRE_LAST);
    // Slow range waits ten fast ticks per base period
    assign base_tick = fast_tick
                    && (ctrl.range_fast || decade == DEC_LAST);
    assign timeout   = base_tick
                    && (period_cnt == ctrl.timeout_code);

    // Prescaler: one fast tick per 10 ms; a control write restarts it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale <= '0;
        end else if (!timer_run || ctrl_wr || fast_tick) begin
            prescale <= '0;
        end else begin
            prescale <= prescale + 1'b1;
        end
    end

    // Decade divider for the 100 ms range
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            decade <= 4'h0;
        end else if (!timer_run || ctrl_wr || base_tick) begin
            decade <= 4'h0;
        end else if (fast_tick) begin
            decade <= decade + 4'h1;
        end
    end

    // Base-period counter, wraps at the timeout code
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            period_cnt <= 3'h0;
        end else if (!timer_run || ctrl_wr || timeout) begin
            period_cnt <= 3'h0;
        end else if (base_tick) begin
            period_cnt <= period_cnt + 3'h1;
        end
    end

    //************************************************************
    // Measurement starts
    //************************************************************

    wam_amp_state_t amp_state;
    wam_amp_state_t next_amp_state;

    // A timeout during a running amplitude run is dropped, not queued
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            amp_meas_start <= 1'b0;
        end else begin
            amp_meas_start <= timeout && ctrl.amp_on_timeout
                           && (amp_state == WAM_AMP_IDLE);
        end
    end

    // Phase unit keeps its own busy state, so every enabled timeout starts it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_meas_start <= 1'b0;
        end else begin
            phase_meas_start <= timeout
                             && ctrl.phase_on_timeout;
        end
    end

    // Capacitance start at every enabled timeout
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_meas_start <= 1'b0;
        end else begin
            cap_meas_start <= timeout
                           && ctrl.cap_on_timeout;
        end
    end

    //************************************************************
    // Amplitude sequencer and comparison
    //************************************************************

    logic [7:0]       amp_reference;
    logic [7:0]       amp_diff;
    logic             amp_exceed;
    logic             avg_take;
    logic signed [9:0] avg_delta;
    logic signed [9:0] avg_step;
    logic [7:0]       next_average;

    // Pick the comparison value
    assign amp_reference = amp_cfg.reference_source_select
                         ? amp_average
                         : fixed_reference_value;
    assign amp_diff   = wam_abs_diff(latest_result_value, amp_reference);
    assign amp_exceed = amp_diff
                      > {4'h0, amp_cfg.amplitude_delta_threshold};
    // Averaging skips an irq-causing result unless told otherwise
    assign avg_take   = !amp_exceed
                      || amp_cfg.include_trigger_in_average;

    // Step toward the new result by delta / weight (floored)
    always_comb begin
        avg_delta = $signed({2'b00, latest_result_value})
                  - $signed({2'b00, amp_average});
        avg_step  = avg_delta
                  >>> wam_weight_shift(amp_cfg.average_weight_code);
        next_average = amp_average + avg_step[7:0];
    end

    // Sequencer state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            amp_state <= WAM_AMP_IDLE;
        end else begin
            amp_state <= next_amp_state;
        end
    end

    // Next state: start, wait for converter, evaluate once
    always_comb begin
        next_amp_state = amp_state;
        unique case (amp_state)
            WAM_AMP_IDLE: begin
                if (amp_meas_start) begin
                    next_amp_state = WAM_AMP_WAIT;
                end
            end
            WAM_AMP_WAIT: begin
                if (amp_meas.done) begin
                    next_amp_state = WAM_AMP_EVAL;
                end
            end
            WAM_AMP_EVAL: begin
                next_amp_state = WAM_AMP_IDLE;
            end
            default: next_amp_state = WAM_AMP_IDLE;
        endcase
    end

    // Latest result captured when the converter finishes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            latest_result_value <= `WAM_RST_AMP_RESULT;
        end else if (amp_state == WAM_AMP_WAIT && amp_meas.done) begin
            latest_result_value <= amp_meas.value;
        end
    end

    // Running average updated in the evaluate cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            amp_average <= `WAM_RST_AMP_AVG;
        end else if (amp_state == WAM_AMP_EVAL && avg_take) begin
            amp_average <= next_average;
        end
    end

    //************************************************************
    // Interrupts
    //************************************************************

    // Event sources for the sticky status bits
    always_comb begin
        irq_set = 4'h0;
        irq_set[`WAM_IRQ_TIMER_BIT] = timeout
                                    && ctrl.irq_every_timeout;
        irq_set[`WAM_IRQ_AMP_BIT]   = (amp_state == WAM_AMP_EVAL)
                                    && amp_exceed;
        irq_set[`WAM_IRQ_PHASE_BIT] = phase_change_evt;
        irq_set[`WAM_IRQ_CAP_BIT]   = cap_change_evt;
    end

    // Write-one-to-clear; a same-cycle event keeps its bit set
    always_comb begin
        next_irq_status = irq_status;
        if (wam_wr_hit(bus_wr, bus_idx, `WAM_IDX_IRQ_STATUS)) begin
            next_irq_status = irq_status & ~wb_dat_i[3:0];
        end
        next_irq_status = next_irq_status | irq_set;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= `WAM_RST_IRQ_STATUS;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    // Level interrupt while any unmasked bit stands
    assign irq = |(irq_status & irq_mask);

endmodule : wam_top

`default_nettype wire

/* File: sim/wam_props.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Port checks for the wake-up monitor
// ****************************************
module wam_props #(
    parameter int unsigned BASE_CYCLES = 20
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        amp_meas_start,
    input wire logic        phase_meas_start,
    input wire logic        cap_meas_start
);
    logic [31:0] gap;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Cycles since the last phase start; zero until the first one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap <= 32'h0;
        end else if (phase_meas_start) begin
            gap <= 32'h1;
        end else if (gap != 32'h0) begin
            gap <= gap + 32'h1;
        end
    end

    req_ack_a: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered in one cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (
        $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    dat_upper_a: assert property (
        wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    amp_pulse_a: assert property (
        amp_meas_start |=> !amp_meas_start)
        else $error("amplitude start longer than one cycle");
    phase_pulse_a: assert property (
        phase_meas_start |=> !phase_meas_start)
        else $error("phase start longer than one cycle");
    cap_pulse_a: assert property (
        cap_meas_start |=> !cap_meas_start)
        else $error("capacitance start longer than one cycle");
    period_min_a: assert property (
        phase_meas_start && gap != 32'h0 |-> gap >= BASE_CYCLES)
        else $error("timeouts closer than one base period");
endmodule : wam_props

bind wam_top wam_props #(.BASE_CYCLES(BASE_CYCLES)) u_props (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .amp_meas_start(amp_meas_start), .phase_meas_start(phase_meas_start),
    .cap_meas_start(cap_meas_start));
`default_nettype wire

/* File: sim/wakeup_amplitude_monitor_tb.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Self-checking bench with integer model
// ****************************************
module wakeup_amplitude_monitor_tb;
    import wam_pkg::*;
    localparam int BASE = 20; // Short base period keeps the run brief
    logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
    logic        pev = 0, cev = 0, ack, irq, ams, pms, cms;
    logic [9:0]  adr = 0;
    logic [3:0]  sel = 4'hf;
    logic [31:0] wdat = 0, rdat;
    logic [7:0]  q;
    wam_meas_t   meas = '0;
    int n_fail = 0, checks = 0, seed = 28354, cycles = 0, used = 0;
    int astarts = 0, pstarts = 0, cstarts = 0, cfg, refv, avg, v, r;
    int df, ex, s, n, p;
    byte ids[7] = '{8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h40, 8'h41};

    wam_top #(.BASE_CYCLES(BASE)) dut_u (.clk(clk), .rst_n(rst_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .amp_meas_start(ams), .amp_meas(meas), .phase_meas_start(pms),
        .phase_change_evt(pev), .cap_meas_start(cms),
        .cap_change_evt(cev), .irq(irq));

    always #5 clk = ~clk;

    // Start pulses last one cycle, so count them here, not in the tasks
    always @(posedge clk) begin
        cycles++;
        astarts += ams;
        pstarts += pms;
        cstarts += cms;
        if (cycles > 30000) begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Classic cycle: hold everything until ack is sampled high
    task automatic bus(input logic [7:0] i, input logic w,
                       input logic [7:0] d);
        @(posedge clk);
        cyc <= 1; stb <= 1; we <= w; adr <= {i, 2'b00};
        wdat <= {24'h0, d};
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        q = rdat[7:0];
        cyc <= 0; stb <= 0; we <= 0;
    endtask : bus

    task automatic wr(input logic [7:0] i, d);
        bus(i, 1'b1, d);
    endtask : wr

    task automatic rd(input logic [7:0] i, e);
        bus(i, 1'b0, 8'h0);
        chk($sformatf("reg %h", i), {24'h0, e}, {24'h0, q});
    endtask : rd

    task automatic print_verdict();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1;
        foreach (ids[i]) rd(ids[i], 8'h0);
        refv = $random(seed) & 255;
        wr(8'h34, refv[7:0]);
        rd(8'h34, refv[7:0]);
        sel <= 4'he; // Lane 0 off: this write must not land
        wr(8'h34, ~refv[7:0]);
        sel <= 4'hf;
        rd(8'h34, refv[7:0]);
        wr(8'h35, 8'hff);
        wr(8'h36, 8'hff);
        rd(8'h35, 8'h0);
        rd(8'h36, 8'h0);
        rd(8'h50, 8'h0);
        $display("registers done");
        // Every timeout code in the fast range, then one slow period
        wr(8'h41, 8'h01);
        for (int c = 0; c < 9; c++) begin
            p = (c < 8) ? (c + 1) * BASE : 10 * BASE;
            wr(8'h40, 8'h0f);
            wr(8'h32, (c < 8) ? 8'h88 | (c << 4) : 8'h08);
            n = 0;
            while (irq !== 1'b1 && n < p + 5) begin
                @(posedge clk);
                n++;
            end
            chk("period", p, (n >= p && n <= p + 2) ? p : n);
        end
        wr(8'h41, 8'h00);
        chk("irq masked", 0, irq);
        rd(8'h40, 8'h01);
        wr(8'h32, 8'h00);
        wr(8'h40, 8'h0f);
        rd(8'h40, 8'h00);
        $display("timer done");
        // Amplitude runs: every weight code with both reference sources
        avg = 0;
        wr(8'h41, 8'h02);
        wr(8'h32, 8'h84);
        for (int k = 0; k < 12; k++) begin
            cfg = ($random(seed) & 8'hf8) | (k % 8);
            refv = $random(seed) & 255;
            wr(8'h33, cfg[7:0]);
            wr(8'h34, refv[7:0]);
            wr(8'h40, 8'h0f);
            n = 0;
            while (astarts == used && n < 200) begin
                @(posedge clk);
                n++;
            end
            used = astarts;
            repeat ($unsigned($random(seed)) % 4) @(posedge clk);
            v = $random(seed) & 255;
            meas <= '{done: 1'b1, value: v[7:0]};
            @(posedge clk);
            meas <= '{done: 1'b0, value: ~v[7:0]};
            r = cfg[0] ? avg : refv;
            s = cfg[7:4]; // Threshold as a signed integer
            df = v - r;
            ex = (df > s || -df > s);
            if (!(ex && !cfg[3])) avg += (v - avg) >>> (cfg[2:1] + 2);
            repeat (3) @(posedge clk);
            rd(8'h36, v[7:0]);
            rd(8'h35, avg[7:0]);
            rd(8'h40, ex ? 8'h02 : 8'h00);
            chk("irq", ex, irq);
        end
        $display("amplitude done");
        wr(8'h32, 8'h00);
        wr(8'h40, 8'h0f);
        wr(8'h41, 8'h0c);
        s = pstarts;
        n = cstarts;
        wr(8'h32, 8'h83);
        repeat (3 * BASE) @(posedge clk);
        chk("phase starts", 1, pstarts >= s + 2);
        chk("cap starts", 1, cstarts >= n + 2);
        pev <= 1;
        cev <= 1;
        @(posedge clk);
        pev <= 0;
        cev <= 0;
        rd(8'h40, 8'h0c);
        chk("irq", 1, irq);
        $display("phase and capacitance done");
        print_verdict();
    end
endmodule : wakeup_amplitude_monitor_tb
`default_nettype wire
